//--- rtl/link_ctl_pkg.sv
// constants and carriers for the link rate snoop and termination control
// assumes a 100 MHz device clock and a decoded register port from the
// device's configuration target
`default_nettype none
package link_ctl_pkg;
   localparam logic [7:0] MISC_LINK_CONTROL_B_OFFSET = 8'h0b;
   localparam int         EDGE_RATE_MSB      = 7;
   localparam int         EDGE_RATE_LSB      = 6;
   localparam int         TERM_MSB           = 4;
   localparam int         TERM_LSB           = 3;
   localparam int         SPEED_BIT          = 2;
   localparam int         FLAG_BIT           = 1;
   localparam int         DISABLE_BIT        = 0;
   localparam logic [1:0] EDGE_RATE_RESET    = 2'h1;
   localparam logic [1:0] TERM_HIGH_OHM      = 2'h0;
   localparam logic [1:0] TERM_NONE          = 2'h1;
   localparam logic [1:0] TERM_FOLLOW        = 2'h2;
   localparam logic [1:0] TERM_LOW_OHM       = 2'h3;
   localparam logic [1:0] TERM_RESET         = TERM_FOLLOW;
   localparam logic       SPEED_RESET        = 1'b0;
   localparam logic       FLAG_RESET         = 1'b0;
   localparam logic       DISABLE_RESET      = 1'b0;
   localparam logic [6:0] SNOOP_TARGET       = 7'h54;
   localparam logic [7:0] SNOOP_OFFSET       = 8'h20;
   localparam int         SNOOP_BIT          = 1;
   localparam int         CLK_MHZ            = 100;
   localparam int         HPD_LOW_TIME_US    = 2000;
   localparam int         HPD_LOW_CYCLES     = HPD_LOW_TIME_US * CLK_MHZ;
   localparam int         HPD_CNT_W          = 24;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [1:0] clock_lane_edge_rate;
      logic [1:0] term_applied;
      logic       bridge_speed_select;
      logic       clock_ratio_flag;
      logic       link_training_disable;
   } link_ctl_t;
endpackage
`default_nettype wire

//--- rtl/link_rate_snoop_and_termination_ctl.sv
// control register 0x0b with the display channel snoop and hot plug timer
// assumes the register port is already decoded by the configuration target
// and that the snooped serial pins and hot plug are asynchronous
`timescale 1ns/1ns
`default_nettype none
module link_rate_snoop_and_termination_ctl
#(
   parameter int HPD_LOW_LIMIT = link_ctl_pkg::HPD_LOW_CYCLES
)
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire link_ctl_pkg::reg_req_t reg_req,
   output logic [7:0]                reg_rdata,
   input  wire logic                 source_side_serial_clock,
   input  wire logic                 source_side_serial_data,
   input  wire logic                 hotplug_sink_input,
   output link_ctl_pkg::link_ctl_t   link_ctl
);
   import link_ctl_pkg::*;

   typedef enum logic [5:0] {
      st_idle    = 6'h01,
      st_addr    = 6'h02,
      st_offs    = 6'h04,
      st_data_wr = 6'h08,
      st_data_rd = 6'h10,
      st_ignore  = 6'h20
   } snoop_state_t;

   // three stage sync; a change counts when stages two and three agree
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic [2:0] hpd_sync_reg;
   logic       scl_reg;
   logic       sda_reg;
   logic       hpd_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         hpd_sync_reg <= 3'h0;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[1:0], source_side_serial_clock};
         sda_sync_reg <= {sda_sync_reg[1:0], source_side_serial_data};
         hpd_sync_reg <= {hpd_sync_reg[1:0], hotplug_sink_input};
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         hpd_reg <= 1'b0;
      end
      else
      begin
         if (scl_sync_reg[2] == scl_sync_reg[1])
            scl_reg <= scl_sync_reg[2];
         if (sda_sync_reg[2] == sda_sync_reg[1])
            sda_reg <= sda_sync_reg[2];
         if (hpd_sync_reg[2] == hpd_sync_reg[1])
            hpd_reg <= hpd_sync_reg[2];
      end
   end

   // filtered levels delayed once for edge detection
   logic scl_d_reg;
   logic sda_d_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         scl_d_reg <= scl_reg;
         sda_d_reg <= sda_reg;
      end
   end

   logic bus_start;
   logic bus_stop;
   logic scl_rise;

   assign bus_start = scl_reg & scl_d_reg & sda_d_reg & ~sda_reg;
   assign bus_stop  = scl_reg & scl_d_reg & ~sda_d_reg & sda_reg;
   assign scl_rise  = scl_reg & ~scl_d_reg;

   // bit and byte assembly; count 8 is the acknowledge slot
   snoop_state_t state_reg;
   logic [3:0]   bit_cnt_reg;
   logic [7:0]   shift_reg;
   logic [7:0]   ptr_reg;
   logic [7:0]   byte_now;
   logic         byte_done;

   assign byte_now  = {shift_reg[6:0], sda_reg};
   assign byte_done = scl_rise & (bit_cnt_reg == 4'h7);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
      end
      else if (bus_start)
      begin
         bit_cnt_reg <= 4'h0;
      end
      else if (scl_rise)
      begin
         shift_reg   <= byte_now;
         bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
      end
   end

   // byte pointer follows the target's auto increment across data bytes
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= st_idle;
         ptr_reg   <= 8'h00;
      end
      else if (bus_start)
      begin
         state_reg <= st_addr;
      end
      else if (bus_stop)
      begin
         state_reg <= st_idle;
      end
      else if (byte_done)
      begin
         unique case (state_reg)
            st_addr:
            begin
               if (byte_now[7:1] != SNOOP_TARGET)
                  state_reg <= st_ignore;
               else if (byte_now[0])
                  state_reg <= st_data_rd;
               else
                  state_reg <= st_offs;
            end
            st_offs:
            begin
               ptr_reg   <= byte_now;
               state_reg <= st_data_wr;
            end
            st_data_wr, st_data_rd:
               ptr_reg <= ptr_reg + 8'h01;
            st_idle, st_ignore:
               state_reg <= state_reg;
         endcase
      end
   end

   logic snoop_hit;
   logic snoop_val;

   assign snoop_hit = byte_done & (ptr_reg == SNOOP_OFFSET)
                    & ((state_reg == st_data_wr) | (state_reg == st_data_rd));
   // a read of zero leaves the flag alone; writes of either value count
   assign snoop_val = byte_now[SNOOP_BIT];

   // hot plug low timer; saturates so the clear fires once per low spell
   logic [HPD_CNT_W-1:0] hpd_cnt_reg;
   logic                 hpd_timeout;

   assign hpd_timeout = ~hpd_reg
                      & (hpd_cnt_reg == HPD_LOW_LIMIT[HPD_CNT_W-1:0]);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         hpd_cnt_reg <= '0;
      else if (hpd_reg)
         hpd_cnt_reg <= '0;
      else if (hpd_cnt_reg <= HPD_LOW_LIMIT[HPD_CNT_W-1:0])
         hpd_cnt_reg <= hpd_cnt_reg + 1'b1;
   end

   logic       reg_hit;
   logic [1:0] edge_rate_reg;
   logic [1:0] term_reg;
   logic       speed_reg;
   logic       flag_reg;
   logic       flag_d_reg;
   logic       disable_reg;
   logic       flag_next;

   assign reg_hit = reg_req.wr & (reg_req.addr == MISC_LINK_CONTROL_B_OFFSET);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         edge_rate_reg <= EDGE_RATE_RESET;
         speed_reg     <= SPEED_RESET;
         disable_reg   <= DISABLE_RESET;
      end
      else if (reg_hit)
      begin
         edge_rate_reg <= reg_req.wdata[EDGE_RATE_MSB:EDGE_RATE_LSB];
         speed_reg     <= reg_req.wdata[SPEED_BIT];
         disable_reg   <= reg_req.wdata[DISABLE_BIT];
      end
   end

   // snoop is applied last so a snooped set is never lost to a clear
   always_comb
   begin
      flag_next = flag_reg;
      if (reg_hit)
         flag_next = reg_req.wdata[FLAG_BIT];
      if (reg_hit & reg_req.wdata[DISABLE_BIT] & ~disable_reg)
         flag_next = 1'b0;
      if (hpd_timeout)
         flag_next = 1'b0;
      if (snoop_hit & ~disable_reg & (snoop_val | (state_reg == st_data_wr)))
         flag_next = snoop_val;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         flag_reg   <= FLAG_RESET;
         flag_d_reg <= FLAG_RESET;
      end
      else
      begin
         flag_reg   <= flag_next;
         flag_d_reg <= flag_reg;
      end
   end

   // auto load is one cycle after the flag rises, so a write made later wins
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         term_reg <= TERM_RESET;
      else if (reg_hit)
         term_reg <= reg_req.wdata[TERM_MSB:TERM_LSB];
      else if (flag_reg & ~flag_d_reg & ~disable_reg)
         term_reg <= TERM_LOW_OHM;
   end

   logic [1:0] term_eff;

   always_comb
   begin
      term_eff = term_reg;
      if (term_reg == TERM_FOLLOW)
         term_eff = (flag_reg & ~disable_reg) ? TERM_LOW_OHM : TERM_NONE;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         link_ctl <= '{clock_lane_edge_rate: EDGE_RATE_RESET,
                       term_applied:         TERM_NONE,
                       bridge_speed_select:  SPEED_RESET,
                       clock_ratio_flag:     FLAG_RESET,
                       link_training_disable: DISABLE_RESET};
         reg_rdata <= 8'h00;
      end
      else
      begin
         link_ctl.clock_lane_edge_rate  <= edge_rate_reg;
         link_ctl.term_applied          <= term_eff;
         link_ctl.bridge_speed_select   <= speed_reg;
         link_ctl.clock_ratio_flag      <= flag_reg;
         link_ctl.link_training_disable <= disable_reg;
         // reserved bit 5 and unmapped offsets read as zero
         reg_rdata <= (reg_req.addr == MISC_LINK_CONTROL_B_OFFSET)
                    ? {edge_rate_reg, 1'b0, term_reg, speed_reg,
                       flag_reg, disable_reg}
                    : 8'h00;
      end
   end
endmodule
`default_nettype wire

//--- testbench/link_ctl_props.sv
// checker for the link control register, snoop flag and termination
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ns
`default_nettype none
module link_ctl_props
#(
   parameter int HPD_LOW_LIMIT = 50
)
(
   input wire logic                    sys_clk,
   input wire logic                    rst,
   input wire link_ctl_pkg::reg_req_t  reg_req,
   input wire logic [7:0]              reg_rdata,
   input wire logic                    source_side_serial_clock,
   input wire logic                    source_side_serial_data,
   input wire logic                    hotplug_sink_input,
   input wire link_ctl_pkg::link_ctl_t link_ctl
);
   import link_ctl_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [15:0] low_cnt_reg;
   logic        reg_wr;
   assign reg_wr = reg_req.wr && reg_req.addr == 8'h0b;
   // raw pin count; the filter delay is covered by the slack below
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         low_cnt_reg <= 16'h0;
      else if (hotplug_sink_input)
         low_cnt_reg <= 16'h0;
      else if (low_cnt_reg != 16'hffff)
         low_cnt_reg <= low_cnt_reg + 16'h1;
   end
   edge_rate_write_a: assert property (reg_wr |-> ##2
      link_ctl.clock_lane_edge_rate == $past(reg_req.wdata[7:6], 2))
      else $error("edge rate not taken");
   bridge_speed_a: assert property (reg_wr |-> ##2
      link_ctl.bridge_speed_select == $past(reg_req.wdata[2], 2))
      else $error("bridge speed not taken");
   disable_write_a: assert property (reg_wr |-> ##2
      link_ctl.link_training_disable == $past(reg_req.wdata[0], 2))
      else $error("disable bit not taken");
   disable_clears_a: assert property (
      $rose(link_ctl.link_training_disable) |-> !link_ctl.clock_ratio_flag)
      else $error("flag kept when disabled");
   write_only_set_a: assert property (link_ctl.link_training_disable &&
      $past(link_ctl.link_training_disable) &&
      $rose(link_ctl.clock_ratio_flag) |-> $past(reg_wr, 2))
      else $error("flag set without write");
   auto_load_a: assert property ($rose(link_ctl.clock_ratio_flag) &&
      !link_ctl.link_training_disable |-> ##[0:2] link_ctl.term_applied == 2'h3)
      else $error("termination not loaded");
   follow_applied_a: assert property (link_ctl.term_applied != 2'h2)
      else $error("follow code applied raw");
   hotplug_clear_a: assert property (
      low_cnt_reg == 16'(HPD_LOW_LIMIT + 10) |-> !link_ctl.clock_ratio_flag)
      else $error("flag kept after hot plug low");
   cover property ($rose(link_ctl.clock_ratio_flag));
   cover property ($rose(link_ctl.link_training_disable));
   cover property (low_cnt_reg == 16'(HPD_LOW_LIMIT));
endmodule
bind link_rate_snoop_and_termination_ctl link_ctl_props
   #(.HPD_LOW_LIMIT(HPD_LOW_LIMIT)) u_props (.sys_clk(sys_clk), .rst(rst),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .link_ctl(link_ctl),
   .source_side_serial_clock(source_side_serial_clock),
   .source_side_serial_data(source_side_serial_data),
   .hotplug_sink_input(hotplug_sink_input));
`default_nettype wire

//--- testbench/src_ddc_model.sv
// behavioural video source on the display data channel
// assumes the device only listens; released lines idle high (pull-ups)
`timescale 1ns/1ns
`default_nettype none
module src_ddc_model
(
   input  wire logic sys_clk,
   output logic      scl,
   output logic      sda
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // one line moves at a time, eight clocks apart, so the snoop
   // filter never sees clock and data change together
   task automatic put(input logic c, input logic d);
      repeat (8) @(negedge sys_clk);
      scl = c;
      sda = d;
   endtask
   task automatic start();
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
      put(1'b1, 1'b0);
      put(1'b0, 1'b0);
   endtask
   // msb first; the ninth bit stands for a low acknowledge
   task automatic send(input logic [7:0] b);
      logic [8:0] s;
      s = {b, 1'b0};
      for (int i = 8; i >= 0; i--)
      begin
         put(1'b0, s[i]);
         put(1'b1, s[i]);
         put(1'b0, s[i]);
      end
   endtask
   task automatic xfer(input logic [7:0] off, input logic [7:0] d,
                       input logic rd);
      start();
      send(8'ha8);
      send(off);
      if (rd)
      begin
         start();
         send(8'ha9);
      end
      send(d);
      put(1'b0, 1'b0);
      put(1'b1, 1'b0);
      put(1'b1, 1'b1);
   endtask
endmodule
`default_nettype wire

//--- testbench/link_rate_snoop_and_termination_ctl_tb.sv
// bench for the link control register, its snoop flag and hot plug
// assumes the source model drives the snooped pins
`timescale 1ns/1ns
`default_nettype none
module link_rate_snoop_and_termination_ctl_tb;
   import link_ctl_pkg::*;
   localparam int LIMIT = 50;
   logic       sys_clk;
   logic       rst;
   reg_req_t   reg_req;
   logic [7:0] reg_rdata;
   logic       scl;
   logic       sda;
   logic       hpd;
   link_ctl_t  link_ctl;
   int         fails;
   int         n_checks;
   link_rate_snoop_and_termination_ctl #(.HPD_LOW_LIMIT(LIMIT)) DUT (
      .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .source_side_serial_clock(scl),
      .source_side_serial_data(sda), .hotplug_sink_input(hpd),
      .link_ctl(link_ctl));
   src_ddc_model u_src (.sys_clk(sys_clk), .scl(scl), .sda(sda));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                  seen, exp);
      end
   endtask
   // outputs expected from a register value
   function automatic logic [6:0] outs(input logic [7:0] r);
      logic [1:0] t;
      t = r[4:3];
      if (t == 2'h2)
         t = (r[1] && !r[0]) ? 2'h3 : 2'h1;
      return {r[7:6], t, r[2:0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_req = '{wr: 1'b1, addr: a, wdata: d};
      @(negedge sys_clk);
      reg_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] exp);
      @(negedge sys_clk);
      reg_req.addr = 8'h0b;
      repeat (2) @(negedge sys_clk);
      check(reg_rdata, exp);
      check({1'b0, link_ctl}, {1'b0, outs(exp)});
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #400000;
      fails++;
      complete_run();
   end
   initial
   begin
      rst = 1'b1;
      reg_req = '0;
      hpd = 1'b1;
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      repeat (6) @(negedge sys_clk);
      rd(8'h50);
      wr(8'h0a, 8'hff);
      rd(8'h50);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h0b, {i[1:0], 1'b1, i[1:0], i[0], 2'b00});
         rd({i[1:0], 1'b0, i[1:0], i[0], 2'b00});
      end
      wr(8'h0b, 8'h50);
      u_src.xfer(8'h21, 8'h02, 1'b0);
      rd(8'h50);
      u_src.xfer(8'h20, 8'h02, 1'b0);
      rd(8'h5a);
      u_src.xfer(8'h20, 8'hfd, 1'b0);
      rd(8'h58);
      wr(8'h0b, 8'h50);
      u_src.xfer(8'h20, 8'h02, 1'b1);
      rd(8'h5a);
      u_src.xfer(8'h20, 8'hfd, 1'b1);
      rd(8'h5a);
      wr(8'h0b, 8'h5b);
      rd(8'h59);
      u_src.xfer(8'h20, 8'h02, 1'b0);
      rd(8'h59);
      wr(8'h0b, 8'h53);
      rd(8'h53);
      wr(8'h0b, 8'h50);
      u_src.xfer(8'h20, 8'h02, 1'b0);
      rd(8'h5a);
      wr(8'h0b, 8'h4a);
      rd(8'h4a);
      // two short drops must each restart the hot plug count
      for (int k = 0; k < 2; k++)
      begin
         hpd = 1'b0;
         repeat (LIMIT - 10) @(negedge sys_clk);
         hpd = 1'b1;
         repeat (8) @(negedge sys_clk);
      end
      rd(8'h4a);
      hpd = 1'b0;
      repeat (LIMIT + 20) @(negedge sys_clk);
      rd(8'h48);
      hpd = 1'b1;
      complete_run();
   end
endmodule
`default_nettype wire
